// File: core/pdzq_pkg.sv
// Package with timing constants and command codes for power-down and calibration sequencing
`default_nettype none
package pdzq_pkg;
	localparam int CLK_MHZ = 100;
	// Timing figures in ns; cycle counts derived and rounded up (least times)
	localparam int T_CKE_NS = 5;
	localparam int T_XP_NS = 6;
	localparam int T_XPDLL_NS = 24;
	localparam int T_RFC_NS = 110;
	localparam int T_RP_NS = 14;
	localparam int T_XS_NS = 120;
	localparam int CYC_CKE = (T_CKE_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_XP = (T_XP_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_XPDLL = (T_XPDLL_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_RFC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_RP = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_XS = (T_XS_NS * CLK_MHZ + 999) / 1000;
	// Calibration windows in nCK
	localparam int CYC_ZQINIT = 512;
	localparam int CYC_ZQOPER = 256;
	localparam int CYC_ZQCS = 64;
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
	// Mid-scale impedance code held until the first calibration lands
	localparam logic [7:0] CODE_RESET = 8'h80;

	typedef enum logic [2:0]
	{
		CMD_NOP,
		CMD_REF,
		CMD_PREA,
		CMD_ZQCL,
		CMD_ZQCS,
		CMD_SRE,
		CMD_OTHER
	} cmd_e;
endpackage
`default_nettype wire

// File: core/pdzq_link_if.sv
// Interface joining controller and device: clock enable, termination, command bus, data enables
`timescale 1ns/100ps
`default_nettype none
interface pdzq_link_if;
	import pdzq_pkg::*;
	logic cke;
	logic odt;
	cmd_e cmd;
	logic dq_oe;
	logic zq_busy;
	modport ctrl
	(
		output cke,
		output odt,
		output cmd,
		output dq_oe,
		input zq_busy
	);
	modport dev
	(
		input cke,
		input odt,
		input cmd,
		input dq_oe,
		output zq_busy
	);
endinterface
`default_nettype wire

// File: core/pdzq_ctrl.sv
// Controller end: sequences power-down, refresh and calibration commands within DRAM timing
// Function
// - Hold power-down at least tPD before exit
// - Wait tXP after exit before Refresh
// - Re-entry only after tXPDLL from exit
// - After early entry, NOP until tRFC
// - No second CKE low within tRFC
// - Long calibration at init or on demand
// - Device calibrates, then updates driver and termination
// - First long gets tZQinit, later tZQoper
// - Short calibration finishes within tZQCS
// - Short calibration corrects 0.5 % in 64 nCK
// - Channel quiet during calibration windows
// - Device disables calibration current when done
// - All banks precharged, tRP met first; PREA is never issued here, tRP is counted from the last wr_req or other_busy
// - Calibration may overlap DLL lock after self-refresh
// - No automatic recalibration on self-refresh exit
// - Calibration no sooner than tXS after self-refresh
// - Shared-resistor calibrations never overlap
// - CKE high throughout calibration
// - Termination off during calibration
// - Data outputs high impedance during calibration
// - Short-calibration interval from drift formula; not computed here, ZQCS is issued only on zqs_req
// - Power-down entry/exit with CKE plus NOP
// - No CKE low during busy operations
`timescale 1ns/100ps
`default_nettype none
module pdzq_ctrl
	import pdzq_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic pd_req,
	input wire logic ref_req,
	input wire logic zql_req,
	input wire logic zqs_req,
	input wire logic sre_req,
	input wire logic odt_req,
	input wire logic wr_req,
	input wire logic other_busy,
	output logic ref_ack,
	output logic zq_ack,
	output logic ctrl_busy,
	output logic in_pd,
	pdzq_link_if.ctrl link
);
	import pdzq_pkg::*;

	typedef enum
	{
		ST_INIT,
		ST_IDLE,
		ST_PD,
		ST_SR,
		ST_ZQ
	} state_e;

	state_e state_q;
	logic cke_q;
	logic odt_q;
	logic dq_oe_q;
	cmd_e cmd_q;
	logic [CNT_W-1:0] pd_cnt_q;
	logic [CNT_W-1:0] xp_cnt_q;
	logic [CNT_W-1:0] xpdll_cnt_q;
	logic [CNT_W-1:0] rfc_cnt_q;
	logic [CNT_W-1:0] rp_cnt_q;
	logic [CNT_W-1:0] xs_cnt_q;
	logic [CNT_W-1:0] zq_cnt_q;
	logic first_zql_q;
	logic ref_ack_q;
	logic zq_ack_q;
	logic pd_ok;
	logic ref_ok;
	logic zq_ok;
	logic exit_ok;

	// gate entry and exit on the live counters
	assign exit_ok = (pd_cnt_q == CNT_ZERO) && (rfc_cnt_q == CNT_ZERO);
	assign pd_ok = (xpdll_cnt_q == CNT_ZERO) && (rfc_cnt_q == CNT_ZERO) && !other_busy;
	assign ref_ok = (xp_cnt_q == CNT_ZERO) && (rfc_cnt_q == CNT_ZERO);
	// Calibration may start while DLL lock runs; tXS, tRP and tRFC gate it, tXPDLL does not
	assign zq_ok = (rp_cnt_q == CNT_ZERO) && (xs_cnt_q == CNT_ZERO) && (rfc_cnt_q == CNT_ZERO)
		&& !link.zq_busy && !other_busy;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_INIT;
			cke_q <= 1'b1;
			cmd_q <= CMD_NOP;
			first_zql_q <= 1'b1;
			ref_ack_q <= 1'b0;
			zq_ack_q <= 1'b0;
		end
		else
		begin
			cmd_q <= CMD_NOP;
			ref_ack_q <= 1'b0;
			zq_ack_q <= 1'b0;
			unique case (state_q)
				ST_INIT:
				begin
					// Initial long calibration after reset
					if (zq_ok)
					begin
						cmd_q <= CMD_ZQCL;
						state_q <= ST_ZQ;
					end
				end
				ST_IDLE:
				begin
					if (zql_req && zq_ok)
					begin
						cmd_q <= CMD_ZQCL;
						state_q <= ST_ZQ;
						first_zql_q <= 1'b0;
					end
					else if (zqs_req && zq_ok)
					begin
						cmd_q <= CMD_ZQCS;
						state_q <= ST_ZQ;
					end
					else if (ref_req && ref_ok)
					begin
						cmd_q <= CMD_REF;
						ref_ack_q <= 1'b1;
					end
					else if (sre_req && pd_ok)
					begin
						cmd_q <= CMD_SRE;
						cke_q <= 1'b0;
						state_q <= ST_SR;
					end
					else if (pd_req && pd_ok)
					begin
						cke_q <= 1'b0;
						state_q <= ST_PD;
					end
				end
				ST_PD:
				begin
					if (!pd_req && exit_ok)
					begin
						cke_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				ST_SR:
				begin
					if (!sre_req && exit_ok)
					begin
						cke_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				ST_ZQ:
				begin
					// Channel kept quiet with CKE high until window ends
					if (zq_cnt_q == CNT_ONE)
					begin
						state_q <= ST_IDLE;
						zq_ack_q <= 1'b1;
						first_zql_q <= 1'b0;
					end
				end
			endcase
		end
	end

	// Calibration busy counter, window chosen by command and first-after-reset
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			zq_cnt_q <= CNT_ZERO;
		else if (cmd_q == CMD_ZQCL)
			zq_cnt_q <= first_zql_q ? CNT_W'(CYC_ZQINIT) : CNT_W'(CYC_ZQOPER);
		else if (cmd_q == CMD_ZQCS)
			zq_cnt_q <= CNT_W'(CYC_ZQCS);
		else if (zq_cnt_q != CNT_ZERO)
			zq_cnt_q <= zq_cnt_q - CNT_ONE;
	end

	// Power-down timing counters
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pd_cnt_q <= CNT_ZERO;
			xp_cnt_q <= CNT_ZERO;
			xpdll_cnt_q <= CNT_ZERO;
			xs_cnt_q <= CNT_ZERO;
		end
		else
		begin
			// Reloaded while the enable is high, so every entry path starts a full hold
			if (cke_q)
				pd_cnt_q <= CNT_W'(CYC_CKE);
			else if (pd_cnt_q != CNT_ZERO)
				pd_cnt_q <= pd_cnt_q - CNT_ONE;
			if (state_q == ST_PD && !pd_req && exit_ok)
			begin
				xp_cnt_q <= CNT_W'(CYC_XP);
				xpdll_cnt_q <= CNT_W'(CYC_XPDLL);
			end
			else
			begin
				if (xp_cnt_q != CNT_ZERO)
					xp_cnt_q <= xp_cnt_q - CNT_ONE;
				if (xpdll_cnt_q != CNT_ZERO)
					xpdll_cnt_q <= xpdll_cnt_q - CNT_ONE;
			end
			if (state_q == ST_SR && !sre_req && exit_ok)
				xs_cnt_q <= CNT_W'(CYC_XS);
			else if (xs_cnt_q != CNT_ZERO)
				xs_cnt_q <= xs_cnt_q - CNT_ONE;
		end
	end

	// Refresh and precharge counters; precharge assumed complete before each calibration
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rfc_cnt_q <= CNT_ZERO;
			rp_cnt_q <= CNT_W'(CYC_RP);
		end
		else
		begin
			if (cmd_q == CMD_REF)
				rfc_cnt_q <= CNT_W'(CYC_RFC);
			else if (rfc_cnt_q != CNT_ZERO)
				rfc_cnt_q <= rfc_cnt_q - CNT_ONE;
			if (wr_req || other_busy)
				rp_cnt_q <= CNT_W'(CYC_RP);
			else if (rp_cnt_q != CNT_ZERO)
				rp_cnt_q <= rp_cnt_q - CNT_ONE;
		end
	end

	// Termination and data drive forced off during calibration
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			odt_q <= 1'b0;
			dq_oe_q <= 1'b0;
		end
		else
		begin
			odt_q <= odt_req && state_q == ST_IDLE && zq_cnt_q == CNT_ZERO;
			dq_oe_q <= wr_req && state_q == ST_IDLE && zq_cnt_q == CNT_ZERO;
		end
	end

	assign link.cke = cke_q;
	assign link.cmd = cmd_q;
	assign link.odt = odt_q;
	assign link.dq_oe = dq_oe_q;
	assign ref_ack = ref_ack_q;
	assign zq_ack = zq_ack_q;
	assign in_pd = (state_q == ST_PD);
	assign ctrl_busy = (state_q == ST_ZQ) || (state_q == ST_INIT);
endmodule
`default_nettype wire

// File: core/pdzq_dev.sv
// Device end: power-down state tracking and calibration engine with value transfer
`timescale 1ns/100ps
`default_nettype none
module pdzq_dev
	import pdzq_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	output logic powered_down,
	output logic self_refresh,
	output logic zq_current_on,
	output logic [7:0] drv_code,
	output logic [7:0] odt_code,
	input wire logic [7:0] cal_target,
	pdzq_link_if.dev link
);
	import pdzq_pkg::*;

	logic pd_q;
	logic sr_q;
	logic first_q;
	logic [CNT_W-1:0] cnt_q;
	logic [7:0] eng_q;
	logic [7:0] drv_q;
	logic [7:0] odt_q;
	logic nop;

	assign nop = (link.cmd == CMD_NOP);

	// Power-down follows CKE samples with NOP; self-refresh enters on CKE low with SRE and exits on CKE high
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pd_q <= 1'b0;
			sr_q <= 1'b0;
		end
		else
		begin
			if (!link.cke && nop && !sr_q)
				pd_q <= 1'b1;
			else if (link.cke && nop)
				pd_q <= 1'b0;
			if (!link.cke && link.cmd == CMD_SRE)
				sr_q <= 1'b1;
			else if (link.cke)
				sr_q <= 1'b0;
		end
	end

	// Calibration engine: window count, stepping, then transfer to I/O codes
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= CNT_ZERO;
			first_q <= 1'b1;
			eng_q <= CODE_RESET;
			drv_q <= CODE_RESET;
			odt_q <= CODE_RESET;
		end
		else if (link.cmd == CMD_ZQCL && link.cke)
		begin
			cnt_q <= first_q ? CNT_W'(CYC_ZQINIT) : CNT_W'(CYC_ZQOPER);
			first_q <= 1'b0;
		end
		else if (link.cmd == CMD_ZQCS && link.cke)
		begin
			cnt_q <= CNT_W'(CYC_ZQCS);
		end
		else if (cnt_q != CNT_ZERO)
		begin
			cnt_q <= cnt_q - CNT_ONE;
			// One step per clock; a short window moves the code at most 64 steps
			if (eng_q < cal_target)
				eng_q <= eng_q + 8'h01;
			else if (eng_q > cal_target)
				eng_q <= eng_q - 8'h01;
			if (cnt_q == CNT_ONE)
			begin
				drv_q <= eng_q;
				odt_q <= eng_q;
			end
		end
	end

	assign zq_current_on = (cnt_q != CNT_ZERO);
	assign link.zq_busy = zq_current_on;
	assign powered_down = pd_q;
	assign self_refresh = sr_q;
	assign drv_code = drv_q;
	assign odt_code = odt_q;
endmodule
`default_nettype wire

// File: test/pdzq_link_chk.sv
// Checker watching the link between controller and device
`timescale 1ns/100ps
`default_nettype none
module pdzq_link_chk
	import pdzq_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cke,
	input wire logic odt,
	input wire pdzq_pkg::cmd_e cmd,
	input wire logic dq_oe,
	input wire logic zq_busy
);
	import pdzq_pkg::*;
	logic [9:0] run_q;
	logic [9:0] exp_q;
	logic first_q;
	logic cke_q;
	logic [3:0] rfc_q;
	logic [1:0] falls_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n)
			run_q <= 10'h000;
		else
			run_q <= zq_busy ? run_q + 10'h001 : 10'h000;
	// Window latched at the command, so a reset in mid-run starts again from the long one
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n)
		begin
			exp_q <= 10'h000;
			first_q <= 1'b1;
		end
		else if (cmd == CMD_ZQCS)
			exp_q <= 10'(CYC_ZQCS);
		else if (cmd == CMD_ZQCL)
		begin
			exp_q <= first_q ? 10'(CYC_ZQINIT) : 10'(CYC_ZQOPER);
			first_q <= 1'b0;
		end
	// Falls of cke in the span after a refresh; saturates so it cannot wrap
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n)
		begin
			cke_q <= 1'b1;
			rfc_q <= 4'h0;
			falls_q <= 2'h0;
		end
		else
		begin
			cke_q <= cke;
			if (cmd == CMD_REF)
			begin
				rfc_q <= 4'(CYC_RFC - 1);
				falls_q <= 2'h0;
			end
			else if (rfc_q != 4'h0)
			begin
				rfc_q <= rfc_q - 4'h1;
				if (cke_q && !cke)
					falls_q <= falls_q | {falls_q[0], 1'b1};
			end
		end
	a_cke_held_cal: assert property (zq_busy |-> cke)
		else $error("cke low while calibrating");
	a_odt_off_cal: assert property (zq_busy |-> !odt)
		else $error("termination on while calibrating");
	a_dq_released_cal: assert property (zq_busy |-> !dq_oe)
		else $error("data driven while calibrating");
	a_bus_quiet_cal: assert property (zq_busy |-> cmd == CMD_NOP)
		else $error("command while calibrating");
	a_cal_window_len: assert property ($fell(zq_busy) |-> run_q == exp_q)
		else $error("calibration window length wrong");
	a_cal_starts_busy: assert property (cmd inside {CMD_ZQCS, CMD_ZQCL} |=> zq_busy)
		else $error("calibration command without busy");
	a_busy_needs_cmd: assert property ($rose(zq_busy) |-> $past(cmd) inside {CMD_ZQCS, CMD_ZQCL})
		else $error("calibration without command");
	a_exit_with_nop: assert property ($rose(cke) |-> cmd == CMD_NOP)
		else $error("exit without idle command");
	a_ref_after_exit: assert property (cmd == CMD_REF |-> cke && $past(cke))
		else $error("refresh too soon after exit");
	a_reentry_gap: assert property ($fell(cke) && cmd == CMD_NOP |-> $past(cke, 2) && $past(cke, 3))
		else $error("re-entry too soon after exit");
	a_one_fall_rfc: assert property (falls_q != 2'h3)
		else $error("two entries within refresh time");
endmodule
`default_nettype wire

// File: test/dram_powerdown_zq_calibration_test.sv
// Testbench driving both ends of the power-down and calibration link
`timescale 1ns/100ps
`default_nettype none
module dram_powerdown_zq_calibration_test;
	import pdzq_pkg::*;
	logic clock = 1'b0;
	logic arst_n, pd_req, ref_req, zql_req, zqs_req, sre_req, odt_req, wr_req, other_busy;
	logic ref_ack, zq_ack, ctrl_busy, in_pd, powered_down, self_refresh, zq_current_on;
	logic [7:0] cal_target, drv_code, odt_code;
	logic cke_d = 1'b1;
	int bad_count = 0, comparisons = 0, cyc = 0, rise_at = 0;
	int min_xp = 999, min_xpdll = 999, min_xs = 999;
	pdzq_link_if link();
	pdzq_ctrl u_pdzq_ctrl (.clock(clock), .arst_n(arst_n), .pd_req(pd_req), .ref_req(ref_req),
		.zql_req(zql_req), .zqs_req(zqs_req), .sre_req(sre_req), .odt_req(odt_req),
		.wr_req(wr_req), .other_busy(other_busy), .ref_ack(ref_ack), .zq_ack(zq_ack),
		.ctrl_busy(ctrl_busy), .in_pd(in_pd), .link(link.ctrl));
	pdzq_dev u_pdzq_dev (.clock(clock), .arst_n(arst_n), .powered_down(powered_down),
		.self_refresh(self_refresh), .zq_current_on(zq_current_on), .drv_code(drv_code),
		.odt_code(odt_code), .cal_target(cal_target), .link(link.dev));
	pdzq_link_chk u_pdzq_link_chk (.clock(clock), .arst_n(arst_n), .cke(link.cke),
		.odt(link.odt), .cmd(link.cmd), .dq_oe(link.dq_oe), .zq_busy(link.zq_busy));
	always #5 clock = ~clock;
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wait_flag(input logic sr, input logic lvl);
		int n;
		for (n = 0; n < 60 && (sr ? self_refresh : in_pd) !== lvl; n++)
			@(negedge clock);
		chk("state flag", 10'(lvl), 10'(sr ? self_refresh : in_pd));
	endtask
	task automatic wait_ref();
		int n;
		for (n = 0; n < 60 && ref_ack !== 1'b1; n++)
			@(negedge clock);
		chk("refresh ack", 10'h001, 10'(ref_ack));
		ref_req = 1'b0;
	endtask
	// Termination is requested throughout, so the controller must mask it itself
	task automatic cal(input logic lng, input logic [7:0] tgt, input int len);
		int n;
		int busy;
		busy = 0;
		cal_target = tgt;
		odt_req = 1'b1;
		zql_req = lng;
		zqs_req = !lng;
		for (n = 0; n < 900 && zq_ack !== 1'b1; n++)
		begin
			@(negedge clock);
			if (link.zq_busy === 1'b1)
			begin
				zql_req = 1'b0;
				zqs_req = 1'b0;
				busy++;
				if (busy == 1)
					chk("ctrl busy", 10'h001, 10'(ctrl_busy));
			end
		end
		@(negedge clock);
		odt_req = 1'b0;
		chk("ctrl free", 10'h000, 10'(ctrl_busy));
		chk("window", 10'(len), 10'(busy));
		chk("drive code", 10'(tgt), 10'(drv_code));
		chk("term code", 10'(tgt), 10'(odt_code));
		chk("zq current", 10'h000, 10'(zq_current_on));
	endtask
	always @(negedge clock)
	begin
		cyc++;
		if (link.cmd == CMD_REF && cyc - rise_at < min_xp)
			min_xp = cyc - rise_at;
		if ((link.cmd == CMD_ZQCS || link.cmd == CMD_ZQCL) && cyc - rise_at < min_xs)
			min_xs = cyc - rise_at;
		if (link.cke === 1'b0 && cke_d === 1'b1 && link.cmd == CMD_NOP && cyc - rise_at < min_xpdll)
			min_xpdll = cyc - rise_at;
		if (link.cke === 1'b1 && cke_d === 1'b0)
			rise_at = cyc;
		cke_d = link.cke;
		if (cyc == 3000)
		begin
			bad_count++;
			$display("mismatch run length expected below 3000 seen 3000");
			complete_run();
		end
	end
	initial
	begin
		{arst_n, pd_req, ref_req, zql_req, zqs_req, sre_req, odt_req, wr_req, other_busy} = 9'h000;
		cal_target = 8'h5A;
		repeat (12) @(negedge clock);
		arst_n = 1'b1;
		cal(1'b1, 8'h5A, CYC_ZQINIT);
		cal(1'b0, 8'h62, CYC_ZQCS);
		cal(1'b1, 8'hA0, CYC_ZQOPER);
		other_busy = 1'b1;
		wr_req = 1'b1;
		pd_req = 1'b1;
		repeat (20) @(negedge clock);
		chk("blocked entry", 10'h000, 10'(in_pd));
		other_busy = 1'b0;
		wr_req = 1'b0;
		ref_req = 1'b1;
		wait_ref();
		wait_flag(1'b0, 1'b1);
		@(negedge clock);
		chk("device asleep", 10'h001, 10'(powered_down));
		pd_req = 1'b0;
		wait_flag(1'b0, 1'b0);
		pd_req = 1'b1;
		wait_flag(1'b0, 1'b1);
		pd_req = 1'b0;
		ref_req = 1'b1;
		wait_ref();
		pd_req = 1'b1;
		wait_flag(1'b0, 1'b1);
		pd_req = 1'b0;
		wait_flag(1'b0, 1'b0);
		sre_req = 1'b1;
		wait_flag(1'b1, 1'b1);
		cal_target = 8'h33;
		sre_req = 1'b0;
		wait_flag(1'b1, 1'b0);
		repeat (2) @(negedge clock);
		chk("code kept", 10'h0A0, 10'(drv_code));
		cal(1'b0, 8'hA6, CYC_ZQCS);
		chk("exit to refresh", 10'h001, 10'(min_xp >= CYC_XP));
		chk("exit to entry", 10'h001, 10'(min_xpdll >= CYC_XPDLL));
		chk("exit to calibration", 10'h001, 10'(min_xs >= CYC_XS));
		complete_run();
	end
endmodule
`default_nettype wire
